// ===== pic_pkg.sv
// package: register map, reset values, vectors and carrier types of the interrupt controller
package pic_pkg;

  // register word indices; the apb byte address is four times the index
  localparam logic [7:0] PIC_IDX_EXT_EN   = 8'ha6;
  localparam logic [7:0] PIC_IDX_EN0      = 8'ha8;
  localparam logic [7:0] PIC_IDX_PRIO_LO  = 8'ha9;
  localparam logic [7:0] PIC_IDX_EN1      = 8'hb8;
  localparam logic [7:0] PIC_IDX_PRIO_HI  = 8'hb9;
  localparam logic [7:0] PIC_IDX_FLAGS    = 8'hc0;
  localparam logic [7:0] PIC_IDX_STATUS   = 8'hc4;
  localparam logic [7:0] PIC_IDX_CTRL     = 8'hc8;

  // reset values and write masks
  localparam logic [7:0] PIC_EXT_EN_RST   = 8'h01;
  localparam logic [7:0] PIC_EN0_RST      = 8'h00;
  localparam logic [7:0] PIC_EN1_RST      = 8'h00;
  localparam logic [7:0] PIC_PRIO_RST     = 8'h00;
  localparam logic [7:0] PIC_FLAGS_RST    = 8'h00;
  localparam logic [7:0] PIC_PRIO_MASK    = 8'h3f;
  localparam logic [7:0] PIC_EN0_MASK     = 8'hbf;
  localparam logic [7:0] PIC_EN1_MASK     = 8'hbf;
  localparam logic [7:0] PIC_EXT_MASK     = 8'h3f;

  // bit positions
  localparam int PIC_EN0_GLOBAL = 7;
  localparam int PIC_EXT_PIN0   = 3;

  // slot count constant, 14; the controller uses 12 vector slots, indexed in ascending vector order
  localparam int PIC_NSRC = 14;
  localparam int PIC_SRC_W = 4;

  // vector addresses, index order is also tie-break order
  localparam logic [15:0] PIC_VEC_PIN      = 16'h0003;
  localparam logic [15:0] PIC_VEC_T0       = 16'h000b;
  localparam logic [15:0] PIC_VEC_PFAIL    = 16'h0013;
  localparam logic [15:0] PIC_VEC_T1       = 16'h001b;
  localparam logic [15:0] PIC_VEC_SERIAL   = 16'h0023;
  localparam logic [15:0] PIC_VEC_T2       = 16'h002b;
  localparam logic [15:0] PIC_VEC_RFSPI    = 16'h0043;
  localparam logic [15:0] PIC_VEC_RADIO    = 16'h004b;
  localparam logic [15:0] PIC_VEC_SBUS     = 16'h0053;
  localparam logic [15:0] PIC_VEC_WAKEPIN  = 16'h005b;
  localparam logic [15:0] PIC_VEC_MISC     = 16'h0063;
  localparam logic [15:0] PIC_VEC_COUNTER  = 16'h006b;

  typedef enum logic [1:0] {
    PIC_IDLE = 2'b00,
    PIC_ACK  = 2'b01
  } pic_state_t;

  // request inputs from peripherals (all already in the core clock domain except the pins)
  typedef struct packed {
    logic timer0_overflow;
    logic timer1_overflow;
    logic timer2_overflow;
    logic timer2_reload;
    logic serial_receive;
    logic serial_transmit;
    logic power_fail_request_n;
    logic rf_spi_ready_request;
    logic radio_request;
    logic spi_master_done;
    logic spi_slave_done;
    logic two_wire_done;
    logic crystal_started_event;
    logic converter_ready_event;
    logic random_ready_event;
    logic counter_wakeup;
  } pic_src_t;

  // core request: vector offered with its priority level; accept and handler return use separate inputs
  typedef struct packed {
    logic        req;
    logic [15:0] vector;
    logic [1:0]  level;
  } pic_core_req_t;

endpackage : pic_pkg

// ===== pic_controller.sv
// prioritized interrupt controller with apb register access
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`default_nettype none
//
// Overview of operation
// - offer taken request's vector; preempt running handler only at strictly higher level
// - timer 0 overflow vectors 0x000b, timer 1 0x001b, both active high
// - power failure request is falling edge only, latched until taken, vector 0x0013
// - serial receive and transmit are active high, shared vector 0x0023
// - timer 2 overflow and reload are active high, shared vector 0x002b
// - spi master, spi slave, two-wire done trigger on either edge, vector 0x0053
// - miscellaneous is or of three ready events, rising edge, vector 0x0063
// - wakeup pin vectors 0x005b, counter wakeup 0x006b, both rising edge
// - wakeup pin polarity set by operating mode bit 2, rising at controller
// - radio, wakeup pin, misc, counter need wakeup configuration enable
// - enable 0 bit 7 is global enable, clear blocks every request
// - enable 0 bits: 5 timer2, 4 serial, 3 timer1, 2 power, 1 timer0, 0 pin
// - enable 1 bits: 7 reload, 5 counter, 4 misc, 3 wake pin, 2 bus, 1 rf, 0 rfspi
// - two-wire, spi master, spi slave share a line, enabled by extended bits 2..0
// - extended bits 5,4,3 route pins 2,1,0 to pin request; resets to 0x01
// - six priority groups pairing sources as listed
// - group n level from bit n of high and low priority registers
// - level is high bit then low bit, 11 highest
// - request flag register holds the eight listed flags
// - flag bits 5..1 auto clear when serviced; bits 7, 6, 0 do not
module pic_controller
  import pic_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire pic_src_t    src_in,
  input  wire logic [2:0]  general_pin_in,
  input  wire logic        wakeup_pin_in,
  input  wire logic        wakeup_pin_polarity_in,
  input  wire logic [3:0]  wakeup_configuration_in,
  output pic_core_req_t    core_req_out,
  input  wire logic        core_ack_in,
  input  wire logic        core_return_in
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and pin synchronisers
  logic [7:0]  ext_en_reg, en0_reg, en1_reg, prio_lo_reg, prio_hi_reg, flags_reg;
  logic [7:0]  flags_next;
  logic [2:0]  gp_meta_reg, gp_sync_reg, gp_prev_reg;
  logic [1:0]  wp_meta_reg, wp_sync_reg;
  logic        wp_prev_reg;
  wire logic   wp_level = wp_sync_reg[0] ^ ~wp_sync_reg[1];
  pic_src_t    src_prev_reg;
  logic [13:0] pend_reg, pend_next;
  logic [3:0]  act_reg, act_next;   // one bit per level in service
  pic_state_t  state_reg;
  logic [3:0]  ack_idx_reg;
  pic_core_req_t req_reg;

  function automatic logic [1:0] top_level(input logic [3:0] act);
    top_level = act[3] ? 2'd3 : act[2] ? 2'd2 : act[1] ? 2'd1 : 2'd0;
  endfunction : top_level

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gp_meta_reg <= 3'h7;
      gp_sync_reg <= 3'h7;
      gp_prev_reg <= 3'h7;
      // polarity high, pin low: the conditioned level starts low, so no false edge after reset
      wp_meta_reg <= 2'h2;
      wp_sync_reg <= 2'h2;
      wp_prev_reg <= 1'b0;
      src_prev_reg <= '0;
    end else begin
      gp_meta_reg <= general_pin_in;
      gp_sync_reg <= gp_meta_reg;
      gp_prev_reg <= gp_sync_reg;
      wp_meta_reg <= {wakeup_pin_polarity_in, wakeup_pin_in};
      wp_sync_reg <= wp_meta_reg;
      wp_prev_reg <= wp_level;
      src_prev_reg <= src_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source conditioning
  wire logic [2:0] pin_sel   = ext_en_reg[5:3];
  wire logic       pin_now   = |(pin_sel & ~gp_sync_reg);
  wire logic       pin_was   = |(pin_sel & ~gp_prev_reg);
  wire logic       pin_evt   = pin_now & ~pin_was;
  wire logic       wp_evt    = wp_level & ~wp_prev_reg & wakeup_configuration_in[1];
  wire logic       pf_evt    = ~src_in.power_fail_request_n & src_prev_reg.power_fail_request_n;
  wire logic       rf_evt    = (src_in.radio_request ^ src_prev_reg.radio_request)
                             & wakeup_configuration_in[0];
  wire logic [2:0] sb_now    = {src_in.two_wire_done, src_in.spi_master_done, src_in.spi_slave_done};
  wire logic [2:0] sb_old    = {src_prev_reg.two_wire_done, src_prev_reg.spi_master_done,
                                src_prev_reg.spi_slave_done};
  wire logic       sb_evt    = |((sb_now ^ sb_old) & ext_en_reg[2:0]);
  wire logic       misc_now  = src_in.crystal_started_event | src_in.converter_ready_event
                             | src_in.random_ready_event;
  wire logic       misc_old  = src_prev_reg.crystal_started_event | src_prev_reg.converter_ready_event
                             | src_prev_reg.random_ready_event;
  wire logic       misc_evt  = misc_now & ~misc_old & wakeup_configuration_in[2];
  wire logic       cnt_evt   = src_in.counter_wakeup & ~src_prev_reg.counter_wakeup
                             & wakeup_configuration_in[3];

  // slot order 0..11 is ascending vector order; timer 0, timer 1 and serial slots are level driven, timer2 is flag latched
  localparam int S_PIN = 0, S_T0 = 1, S_PF = 2, S_T1 = 3, S_SER = 4, S_T2 = 5, S_RFSPI = 6;
  localparam int S_RF = 7, S_SB = 8, S_WP = 9, S_MISC = 10, S_CNT = 11;

  ////////////////////////////////////////////////////////////////////////////
  // flags register: hardware set beats software clear
  wire logic apb_wr   = psel_in & penable_in & pwrite_in;
  wire logic [7:0] word = paddr_in[9:2];
  wire logic wr_flags = apb_wr & (word == PIC_IDX_FLAGS);
  wire logic [7:0] flag_set = {src_in.timer2_reload, src_in.timer2_overflow, cnt_evt, misc_evt,
                               wp_evt, sb_evt, rf_evt, src_in.rf_spi_ready_request};
  wire logic [7:0] auto_clr = 8'h3e;

  always_comb begin
    flags_next = flags_reg;
    if (wr_flags)
      flags_next = pwdata_in[7:0];
    if (state_reg == PIC_ACK && core_ack_in) begin
      case (ack_idx_reg)
        4'(S_RF):   flags_next[1] = flags_next[1] & ~auto_clr[1];
        4'(S_SB):   flags_next[2] = flags_next[2] & ~auto_clr[2];
        4'(S_WP):   flags_next[3] = flags_next[3] & ~auto_clr[3];
        4'(S_MISC): flags_next[4] = flags_next[4] & ~auto_clr[4];
        4'(S_CNT):  flags_next[5] = flags_next[5] & ~auto_clr[5];
        default:    flags_next = flags_next;
      endcase
    end
    flags_next = flags_next | flag_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending latches for edge sources outside the flag register
  always_comb begin
    pend_next = pend_reg;
    if (state_reg == PIC_ACK && core_ack_in)
      pend_next[ack_idx_reg] = 1'b0;
    pend_next[S_PIN] = pend_next[S_PIN] | pin_evt;
    pend_next[S_PF]  = pend_next[S_PF] | pf_evt;
  end

  // raw request per slot, before enables
  wire logic [11:0] raw = {flags_reg[5], flags_reg[4], flags_reg[3], flags_reg[2], flags_reg[1],
                           flags_reg[0], flags_reg[6] | flags_reg[7],
                           src_in.serial_receive | src_in.serial_transmit,
                           src_in.timer1_overflow, pend_reg[S_PF], src_in.timer0_overflow,
                           pend_reg[S_PIN]};
  wire logic        glob = en0_reg[PIC_EN0_GLOBAL];
  wire logic [11:0] ena  = {en1_reg[5], en1_reg[4], en1_reg[3], en1_reg[2], en1_reg[1], en1_reg[0],
                            en0_reg[5] & (flags_reg[6] | en1_reg[7]),
                            en0_reg[4], en0_reg[3], en0_reg[2], en0_reg[1], en0_reg[0]};
  wire logic [11:0] live = glob ? (raw & ena) : 12'h000;

  // group of each slot, in slot order
  function automatic logic [2:0] group_of(input int s);
    case (s)
      S_PIN, S_RFSPI: group_of = 3'd0;
      S_T0, S_RF:     group_of = 3'd1;
      S_PF, S_SB:     group_of = 3'd2;
      S_T1, S_WP:     group_of = 3'd3;
      S_SER, S_MISC:  group_of = 3'd4;
      default:        group_of = 3'd5;
    endcase
  endfunction : group_of

  function automatic logic [15:0] vec_of(input logic [3:0] s);
    case (s)
      4'd0:    vec_of = PIC_VEC_PIN;
      4'd1:    vec_of = PIC_VEC_T0;
      4'd2:    vec_of = PIC_VEC_PFAIL;
      4'd3:    vec_of = PIC_VEC_T1;
      4'd4:    vec_of = PIC_VEC_SERIAL;
      4'd5:    vec_of = PIC_VEC_T2;
      4'd6:    vec_of = PIC_VEC_RFSPI;
      4'd7:    vec_of = PIC_VEC_RADIO;
      4'd8:    vec_of = PIC_VEC_SBUS;
      4'd9:    vec_of = PIC_VEC_WAKEPIN;
      4'd10:   vec_of = PIC_VEC_MISC;
      default: vec_of = PIC_VEC_COUNTER;
    endcase
  endfunction : vec_of

  ////////////////////////////////////////////////////////////////////////////
  // arbitration: highest level, then lowest slot
  logic [3:0] win_idx;
  logic [1:0] win_lvl;
  logic       win_ok;
  always_comb begin
    logic [1:0] l;
    l       = 2'd0;
    win_idx = 4'd0;
    win_lvl = 2'd0;
    win_ok  = 1'b0;
    for (int s = 11; s >= 0; s--) begin
      l = {prio_hi_reg[group_of(s)], prio_lo_reg[group_of(s)]};
      if (live[s] && (!win_ok || l >= win_lvl)) begin
        win_idx = 4'(s);
        win_lvl = l;
        win_ok  = 1'b1;
      end
    end
  end

  wire logic busy     = |act_reg;
  wire logic can_take = win_ok && (!busy || win_lvl > top_level(act_reg));

  always_comb begin
    act_next = act_reg;
    if (core_return_in)
      act_next[top_level(act_reg)] = 1'b0;
    if (state_reg == PIC_ACK && core_ack_in)
      act_next[req_reg.level] = 1'b1;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg   <= PIC_IDLE;
      ack_idx_reg <= 4'd0;
      req_reg     <= '0;
      act_reg     <= 4'h0;
      pend_reg    <= 14'h0000;
      flags_reg   <= PIC_FLAGS_RST;
    end else begin
      act_reg   <= act_next;
      pend_reg  <= pend_next;
      flags_reg <= flags_next;
      case (state_reg)
        PIC_IDLE: begin
          if (can_take) begin
            state_reg   <= PIC_ACK;
            ack_idx_reg <= win_idx;
            req_reg     <= '{req: 1'b1, vector: vec_of(win_idx), level: win_lvl};
          end
        end
        PIC_ACK: begin
          if (core_ack_in) begin
            state_reg   <= PIC_IDLE;
            req_reg.req <= 1'b0;
          end
        end
        default: state_reg <= PIC_IDLE;
      endcase
    end
  end

  assign core_req_out = req_reg;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_en_reg  <= PIC_EXT_EN_RST;
      en0_reg     <= PIC_EN0_RST;
      en1_reg     <= PIC_EN1_RST;
      prio_lo_reg <= PIC_PRIO_RST;
      prio_hi_reg <= PIC_PRIO_RST;
    end else if (apb_wr) begin
      case (word)
        PIC_IDX_EXT_EN:  ext_en_reg  <= pwdata_in[7:0] & PIC_EXT_MASK;
        PIC_IDX_EN0:     en0_reg     <= pwdata_in[7:0] & PIC_EN0_MASK;
        PIC_IDX_EN1:     en1_reg     <= pwdata_in[7:0] & PIC_EN1_MASK;
        PIC_IDX_PRIO_LO: prio_lo_reg <= pwdata_in[7:0] & PIC_PRIO_MASK;
        PIC_IDX_PRIO_HI: prio_hi_reg <= pwdata_in[7:0] & PIC_PRIO_MASK;
        default:         en0_reg     <= en0_reg;
      endcase
    end
  end

  wire logic mapped = (word == PIC_IDX_EXT_EN) || (word == PIC_IDX_EN0) || (word == PIC_IDX_EN1)
                   || (word == PIC_IDX_PRIO_LO) || (word == PIC_IDX_PRIO_HI)
                   || (word == PIC_IDX_FLAGS) || (word == PIC_IDX_STATUS);
  wire logic [7:0] rd_byte =
      (word == PIC_IDX_EXT_EN)  ? ext_en_reg  :
      (word == PIC_IDX_EN0)     ? en0_reg     :
      (word == PIC_IDX_EN1)     ? en1_reg     :
      (word == PIC_IDX_PRIO_LO) ? prio_lo_reg :
      (word == PIC_IDX_PRIO_HI) ? prio_hi_reg :
      (word == PIC_IDX_FLAGS)   ? flags_reg   :
      (word == PIC_IDX_STATUS)  ? {act_reg, ack_idx_reg} : 8'h00;

  assign prdata_out  = {24'h000000, rd_byte};
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & (~mapped | (pwrite_in & (word == PIC_IDX_STATUS)));

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_GLOBAL_OFF: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state_reg == PIC_IDLE && !en0_reg[PIC_EN0_GLOBAL]) |=> !core_req_out.req)
    else $error("request offered with global enable clear");
  AST_PREEMPT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(core_req_out.req) && $past(busy) |-> core_req_out.level > $past(top_level(act_reg)))
    else $error("handler preempted by equal or lower level");
  AST_EXT_RESET: assert property (@(posedge ref_clk_in)
    $rose(rst_n_in) |-> ext_en_reg == 8'h01)
    else $error("extended enable reset value wrong");
  AST_T0_VEC: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(core_req_out.req) && ack_idx_reg == 4'(S_T0) |-> core_req_out.vector == 16'h000b)
    else $error("timer 0 vector wrong");
  AST_SB_VEC: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(core_req_out.req) && ack_idx_reg == 4'(S_SB) |-> core_req_out.vector == 16'h0053)
    else $error("serial bus vector wrong");
  AST_FLAG_SET: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    misc_evt |=> flags_reg[4])
    else $error("misc event lost");
  AST_NOCLR_T2: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    flags_reg[6] && !wr_flags |=> flags_reg[6])
    else $error("timer 2 flag cleared without software");
  AST_AUTOCLR: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_reg == PIC_ACK && core_ack_in && ack_idx_reg == 4'(S_RF) && !rf_evt && !wr_flags
    |=> !flags_reg[1])
    else $error("radio flag not auto cleared");

endmodule : pic_controller
`default_nettype wire

// ===== pic_core_model.sv
// partner model of the processor core: takes offered vectors and runs nested handlers
`timescale 1ns/100ps
`default_nettype none
module pic_core_model
  import pic_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire pic_core_req_t req_in,
  input  wire logic [3:0]    ack_wait_in,
  input  wire logic [7:0]    hold_in,
  output logic               ack_out,
  output logic               return_out,
  output logic [15:0]        vector_out,
  output logic [7:0]         taken_out
);
  logic [3:0] wait_reg;
  logic [7:0] run_reg;
  logic [3:0] depth_reg;
  // one return per taken handler, innermost first; a new take restarts the handler time
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out    <= 1'b0;
      return_out <= 1'b0;
      vector_out <= 16'h0000;
      taken_out  <= 8'h00;
      wait_reg   <= 4'h0;
      run_reg    <= 8'h00;
      depth_reg  <= 4'h0;
    end else begin
      ack_out    <= 1'b0;
      return_out <= 1'b0;
      run_reg    <= run_reg + 8'h01;
      // ack_out guard: req is still high at the edge that samples our ack
      if (req_in.req && !ack_out && wait_reg < ack_wait_in) begin
        wait_reg <= wait_reg + 4'h1;
      end else if (req_in.req && !ack_out) begin
        ack_out    <= 1'b1;
        vector_out <= req_in.vector;
        taken_out  <= taken_out + 8'h01;
        depth_reg  <= depth_reg + 4'h1;
        wait_reg   <= 4'h0;
        run_reg    <= 8'h00;
      end else if (depth_reg != 4'h0 && run_reg >= hold_in) begin
        return_out <= 1'b1;
        depth_reg  <= depth_reg - 4'h1;
        run_reg    <= 8'h00;
      end
    end
  end
endmodule : pic_core_model
`default_nettype wire

// ===== tb_top.sv
// self-checking bench of the interrupt controller against a core model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pic_pkg::*;
  // stimulus word: {wake pin, general pins[2:0], source struct}
  localparam logic [19:0] IDLE = 20'h70200;
  localparam logic [7:0]  RIDX [6] = '{PIC_IDX_EXT_EN, PIC_IDX_EN0, PIC_IDX_PRIO_LO,
                                       PIC_IDX_EN1, PIC_IDX_PRIO_HI, PIC_IDX_FLAGS};
  localparam logic [7:0]  RRST [6] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0]  RMSK [6] = '{8'h3f, 8'hbf, 8'h3f, 8'hbf, 8'h3f, 8'hff};
  localparam int          SBIT [18] = '{16, 15, 9, 14, 11, 10, 13, 12, 8, 7, 6, 5, 4, 19, 3, 2, 1, 0};
  localparam logic [15:0] SVEC [18] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h0023,
    16'h002b, 16'h002b, 16'h0043, 16'h004b, 16'h0053, 16'h0053, 16'h0053, 16'h005b, 16'h0063,
    16'h0063, 16'h0063, 16'h006b};
  localparam int          PBIT [3] = '{15, 14, 11};
  localparam int          PGRP [3] = '{1, 3, 4};
  logic          clk, rst_n, psel, penable, pwrite, pready, pslverr, ack, ret, err, pol;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd, d;
  logic [19:0]   stim;
  logic [3:0]    wcfg, ack_wait;
  logic [7:0]    hold, base, lo, hi;
  logic [15:0]   vec;
  logic [7:0]    taken;
  logic [2:0]    left;
  pic_core_req_t core_req;
  int            n_fail, n_compared, seed, s;

  pic_controller u_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .src_in(pic_src_t'(stim[15:0])), .general_pin_in(stim[18:16]),
    .wakeup_pin_in(stim[19]), .wakeup_pin_polarity_in(pol), .wakeup_configuration_in(wcfg),
    .core_req_out(core_req), .core_ack_in(ack), .core_return_in(ret));
  pic_core_model u_core (.clk_in(clk), .rst_n_in(rst_n), .req_in(core_req), .ack_wait_in(ack_wait),
    .hold_in(hold), .ack_out(ack), .return_out(ret), .vector_out(vec), .taken_out(taken));

  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // bounded wait for the core to take a new vector
  task wait_take(input logic [7:0] from);
    int i;
    i = 0;
    while (taken === from && i < 300) begin
      @(posedge clk);
      i++;
    end
    check(i < 300, 1);
  endtask : wait_take

  // next source to be served: highest level, lowest vector on a tie
  function automatic int pick(input logic [7:0] l, input logic [7:0] h, input logic [2:0] m);
    int b;
    b = -1;
    for (int j = 0; j < 3; j++)
      if (m[j] && (b < 0 || {h[PGRP[j]], l[PGRP[j]]} > {h[PGRP[b]], l[PGRP[b]]})) b = j;
    return b;
  endfunction : pick

  task complete_run;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #(50 * 40000);
    n_fail++;
    complete_run();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_n, ack_wait} = '0;
    seed = 32'h44b4;
    pol = 1'b1;
    stim = IDLE;
    wcfg = 4'hf;
    hold = 8'd20;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, RIDX[k], 32'h0);
      check(rd, {24'h0, RRST[k]});
    end
    for (int k = 0; k < 6; k++) begin
      d = $random(seed);
      d[7] = d[7] & (k != 1);
      if (k == 0) d[5:4] = 2'b00;
      apb(1'b1, RIDX[k], d);
      apb(1'b0, RIDX[k], 32'h0);
      check(rd, {24'h0, d[7:0] & RMSK[k]});
    end
    apb(1'b1, PIC_IDX_FLAGS, 32'h0);
    apb(1'b0, 8'hff, 32'h0);
    check(err, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, PIC_IDX_EXT_EN, 32'h0f);
    apb(1'b1, PIC_IDX_EN1, 32'hbf);
    apb(1'b1, PIC_IDX_PRIO_LO, 32'h0);
    apb(1'b1, PIC_IDX_PRIO_HI, 32'h0);
    apb(1'b1, PIC_IDX_EN0, 32'h3f);
    // global enable clear: timer 0 must wait
    base = taken;
    stim <= IDLE ^ 20'h08000;
    repeat (20) @(posedge clk);
    check(taken, base);
    apb(1'b1, PIC_IDX_EN0, 32'hbf);
    wait_take(base);
    check(vec, 16'h000b);
    stim <= IDLE;
    // radio without wakeup configuration stays silent
    wcfg <= 4'h0;
    base = taken;
    repeat (30) @(posedge clk);
    stim <= IDLE ^ 20'h00080;
    repeat (20) @(posedge clk);
    stim <= IDLE;
    check(taken, base);
    apb(1'b1, PIC_IDX_FLAGS, 32'h0);
    wcfg <= 4'hf;
    repeat (40) @(posedge clk);
    // every source once; either-edge ones fire again on release
    for (int k = 0; k < 18; k++) begin
      base = taken;
      stim <= IDLE ^ (20'h1 << SBIT[k]);
      wait_take(base);
      check(vec, SVEC[k]);
      stim <= IDLE;
      apb(1'b0, PIC_IDX_FLAGS, 32'h0);
      // either-edge sources keep the flag of their release edge for the second take
      if (SBIT[k] < 4 || SBIT[k] > 7) begin
        check(rd, (SBIT[k] == 13) ? 32'h40 : (SBIT[k] == 12) ? 32'h80 : (SBIT[k] == 8) ? 32'h01 : 32'h0);
        apb(1'b1, PIC_IDX_FLAGS, 32'h0);
      end
      repeat (80) @(posedge clk);
      check(taken, base + ((SBIT[k] >= 4 && SBIT[k] <= 7) ? 8'd2 : 8'd1));
      check(vec, SVEC[k]);
    end
    // falling-active wake pin: polarity and pin change together, then the pin falls
    base = taken;
    pol <= 1'b0;
    stim <= IDLE | 20'h80000;
    repeat (10) @(posedge clk);
    check(taken, base);
    stim <= IDLE;
    wait_take(base);
    check(vec, 16'h005b);
    pol <= 1'b1;
    repeat (40) @(posedge clk);
    // random levels, three sources raised at once
    for (int r = 0; r < 8; r++) begin
      lo = $random(seed);
      hi = $random(seed);
      ack_wait <= 4'({$random(seed)} % 4);
      apb(1'b1, PIC_IDX_PRIO_LO, {24'h0, lo});
      apb(1'b1, PIC_IDX_PRIO_HI, {24'h0, hi});
      apb(1'b1, PIC_IDX_EN0, 32'h3f);
      stim <= IDLE | 20'h0c800;
      apb(1'b1, PIC_IDX_EN0, 32'hbf);
      left = 3'b111;
      for (int j = 0; j < 3; j++) begin
        s = pick(lo, hi, left);
        base = taken;
        wait_take(base);
        check(vec, SVEC[s == 0 ? 1 : s == 1 ? 3 : 4]);
        left[s] = 1'b0;
        stim[PBIT[s]] <= 1'b0;
      end
      repeat (80) @(posedge clk);
    end
    // higher level preempts a running handler, lower level waits
    hold <= 8'd60;
    apb(1'b1, PIC_IDX_PRIO_LO, 32'h08);
    apb(1'b1, PIC_IDX_PRIO_HI, 32'h08);
    base = taken;
    stim <= IDLE ^ 20'h08000;
    wait_take(base);
    stim <= IDLE | 20'h04800;
    base = taken;
    wait_take(base);
    check(vec, 16'h001b);
    stim <= IDLE | 20'h00800;
    repeat (20) @(posedge clk);
    check(taken, base + 8'd1);
    base = taken;
    wait_take(base);
    check(vec, 16'h0023);
    stim <= IDLE;
    repeat (150) @(posedge clk);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
